// File: common/hspm_defines.svh
// offsets, field positions and reset values of the swap and bridge power registers
`ifndef HSPM_DEFINES_SVH
`define HSPM_DEFINES_SVH

`define HSPM_OFS_BRIDGE_SUPPORT 8'hE2
`define HSPM_OFS_POWER_DATA     8'hE3
`define HSPM_OFS_SWAP_ID        8'hE4
`define HSPM_OFS_SWAP_NEXT      8'hE5
`define HSPM_OFS_SWAP_CTRL      8'hE6
`define HSPM_OFS_POWER_CTRL     8'hE0

`define HSPM_BIT_BUS_POWER_EN   7
`define HSPM_BIT_B2B3_SUPPORT   6
`define HSPM_BIT_INSERTED       7
`define HSPM_BIT_EXTRACTED      6
`define HSPM_BIT_LED            3
`define HSPM_BIT_ENUM_MASK      1

`define HSPM_SWAP_ID_NATIVE     8'h06
`define HSPM_SWAP_ID_COMPAT     8'h00
`define HSPM_NEXT_PTR           8'h00
`define HSPM_POWER_DATA         8'h00
`define HSPM_POWER_STATE_RST    2'h0
`define HSPM_POWER_STATE_D3HOT  2'h3
`define HSPM_CTRL_RST           8'h00

`endif

// File: common/hspm_pkg.sv
// types shared by the swap and bridge power register block
package hspm_pkg;

   typedef enum logic [1:0] {
      HSPM_D0,
      HSPM_D1,
      HSPM_D2,
      HSPM_D3HOT
   } hspm_pstate_e;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hspm_cfg_req_s;

   typedef struct packed {
      logic inserted;
      logic extracted;
      logic led;
      logic enum_mask;
   } hspm_swap_s;

endpackage

// File: hw/hspm_regs.sv
// swap capability, bridge power support and power data configuration registers
`include "hspm_defines.svh"

module hspm_regs
(
   input  wire logic                  clock_i,
   input  wire logic                  rst_b_i,
   input  wire hspm_pkg::hspm_cfg_req_s cfg_req_i,
   input  wire logic                  cfg_req_valid_i,
   input  wire logic                  compat_mode_i,
   input  wire logic                  bus_power_strap_in,
   input  wire logic                  rom_preload_done_i,
   input  wire logic                  ejector_closed_i,
   output logic [7:0]                 cfg_rdata_o,
   output logic                       swap_enumeration_out,
   output logic                       swap_indicator_led_out,
   output logic                       sec_clock_run_o
);

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   // no reset on these flops on purpose: they keep tracking the pins while reset is held,
   // so the first edge after release sees the true handle level and a board that comes
   // out of reset with its handle closed never latches a false extraction
   logic [2:0] pin_raw;
   logic [2:0] pin_sync;

   assign pin_raw = {bus_power_strap_in, rom_preload_done_i, ejector_closed_i};

   for (genvar g = 0; g < 3; g++)
   begin : g_sync
      logic meta_r;
      logic sync_r;

      always_ff @(posedge clock_i)
      begin
         meta_r <= pin_raw[g];
         sync_r <= meta_r;
      end

      assign pin_sync[g] = sync_r;
   end

   logic strap;
   logic preload_done;
   logic handle_closed;
   assign strap         = pin_sync[2];
   assign preload_done  = pin_sync[1];
   assign handle_closed = pin_sync[0];

   // -------------------------------------------------------------
   // control state
   // -------------------------------------------------------------
   hspm_pkg::hspm_swap_s   swap_r;
   hspm_pkg::hspm_swap_s   swap_nxt;
   hspm_pkg::hspm_pstate_e pstate_r;
   hspm_pkg::hspm_pstate_e pstate_nxt;
   logic                   led_hold_r;
   logic                   led_hold_nxt;
   logic [7:0]             rdata_nxt;
   logic                   enum_nxt;
   logic                   led_nxt;
   logic                   clk_run_nxt;
   logic                   wr_ctrl;
   logic                   wr_pm;

   assign wr_ctrl = cfg_req_valid_i && cfg_req_i.wr && (cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL);
   // power state kept here to steer the secondary clocks and to be read back at the power control offset
   assign wr_pm   = cfg_req_valid_i && cfg_req_i.wr && (cfg_req_i.addr == `HSPM_OFS_POWER_CTRL);

   always_comb
   begin
      swap_nxt     = swap_r;
      pstate_nxt   = pstate_r;
      led_hold_nxt = led_hold_r;
      if (wr_ctrl)
      begin
         // only the two writable bits take write data; status bits are untouched
         swap_nxt.led       = cfg_req_i.wdata[`HSPM_BIT_LED];
         swap_nxt.enum_mask = cfg_req_i.wdata[`HSPM_BIT_ENUM_MASK];
      end
      if (wr_pm)
      begin
         pstate_nxt = hspm_pkg::hspm_pstate_e'(cfg_req_i.wdata[1:0]);
      end
      // sticky until reset; mask plays no part here
      if (preload_done && handle_closed && !swap_r.extracted)
      begin
         swap_nxt.inserted = 1'b1;
      end
      if (!handle_closed && !swap_r.inserted)
      begin
         swap_nxt.extracted = 1'b1;
      end
      if (handle_closed)
      begin
         led_hold_nxt = 1'b0;
      end
   end

   always_comb
   begin
      enum_nxt    = (swap_nxt.inserted || swap_nxt.extracted) && !swap_nxt.enum_mask;
      led_nxt     = led_hold_nxt ? 1'b1 : swap_nxt.led;
      // the run flag drops only when the strap is set and the next power state is D3hot
      clk_run_nxt = !(strap && (pstate_nxt == hspm_pkg::HSPM_D3HOT));
   end

   // -------------------------------------------------------------
   // read path
   // -------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (cfg_req_valid_i && !cfg_req_i.wr)
      begin
         case (cfg_req_i.addr)
            `HSPM_OFS_BRIDGE_SUPPORT:
            begin
               rdata_nxt[`HSPM_BIT_BUS_POWER_EN] = strap;
               rdata_nxt[`HSPM_BIT_B2B3_SUPPORT] = strap;
            end
            `HSPM_OFS_POWER_DATA: rdata_nxt = `HSPM_POWER_DATA;
            `HSPM_OFS_SWAP_ID:
            begin
               rdata_nxt = compat_mode_i ? `HSPM_SWAP_ID_COMPAT : `HSPM_SWAP_ID_NATIVE;
            end
            `HSPM_OFS_SWAP_NEXT: rdata_nxt = `HSPM_NEXT_PTR;
            `HSPM_OFS_SWAP_CTRL:
            begin
               // bits 5, 4, 2, 0 stay zero
               rdata_nxt[`HSPM_BIT_INSERTED]  = swap_r.inserted;
               rdata_nxt[`HSPM_BIT_EXTRACTED] = swap_r.extracted;
               rdata_nxt[`HSPM_BIT_LED]       = swap_r.led;
               rdata_nxt[`HSPM_BIT_ENUM_MASK] = swap_r.enum_mask;
            end
            `HSPM_OFS_POWER_CTRL: rdata_nxt[1:0] = pstate_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         swap_r                 <= '0;
         pstate_r               <= hspm_pkg::HSPM_D0;
         led_hold_r             <= 1'b1;
         cfg_rdata_o            <= 8'h00;
         swap_enumeration_out   <= 1'b0;
         swap_indicator_led_out <= 1'b1;
         sec_clock_run_o        <= 1'b1;
      end
      else
      begin
         swap_r                 <= swap_nxt;
         pstate_r               <= pstate_nxt;
         led_hold_r             <= led_hold_nxt;
         cfg_rdata_o            <= rdata_nxt;
         swap_enumeration_out   <= enum_nxt;
         swap_indicator_led_out <= led_nxt;
         sec_clock_run_o        <= clk_run_nxt;
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   AST_INS_STICKY: assert property (swap_r.inserted |=> swap_r.inserted)
      else $error("inserted status dropped");
   AST_EXT_STICKY: assert property (swap_r.extracted |=> swap_r.extracted)
      else $error("extracted status dropped");
   AST_INS_SET: assert property (!swap_r.inserted && preload_done && handle_closed && !swap_r.extracted
      |=> swap_r.inserted)
      else $error("inserted status not set");
   AST_INS_CAUSE: assert property ($rose(swap_r.inserted) |-> $past(handle_closed) && $past(preload_done))
      else $error("inserted set without cause");
   AST_EXT_SET: assert property (!handle_closed && !swap_r.inserted |=> swap_r.extracted)
      else $error("extracted status not set");
   AST_ENUM: assert property ((swap_r.inserted || swap_r.extracted) && !swap_r.enum_mask
      |-> swap_enumeration_out)
      else $error("enumeration output not driven");
   AST_ENUM_MASK: assert property (swap_r.enum_mask |-> !swap_enumeration_out)
      else $error("enumeration output not masked");
   AST_LED_HOLD: assert property (led_hold_r |-> swap_indicator_led_out)
      else $error("led not held high");
   AST_LED_FOLLOW: assert property (!led_hold_r |-> swap_indicator_led_out == swap_r.led)
      else $error("led does not follow bit");
   // the run flag is registered from the synchronised strap, so it lags the strap by one edge
   AST_CLK_STOP: assert property ($past(strap) && pstate_r == hspm_pkg::HSPM_D3HOT |-> !sec_clock_run_o)
      else $error("secondary clocks not stopped");
   AST_RD_ID: assert property (cfg_req_valid_i && !cfg_req_i.wr && cfg_req_i.addr == `HSPM_OFS_SWAP_ID
      && !compat_mode_i |=> cfg_rdata_o == `HSPM_SWAP_ID_NATIVE)
      else $error("capability id wrong");

   // -------------------------------------------------------------
   // assertions on register reads
   // -------------------------------------------------------------
   // read data stands for one cycle only, so every check looks one edge after the request
   logic rd_req;
   logic wr_req;
   assign rd_req = cfg_req_valid_i && !cfg_req_i.wr;
   assign wr_req = cfg_req_valid_i && cfg_req_i.wr;

   AST_RD_BUS_PWR: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_BRIDGE_SUPPORT
      |=> cfg_rdata_o[`HSPM_BIT_BUS_POWER_EN] == $past(strap))
      else $error("bus power enable bit does not follow strap");
   AST_RD_B2B3: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_BRIDGE_SUPPORT
      |=> cfg_rdata_o[`HSPM_BIT_B2B3_SUPPORT] == $past(strap))
      else $error("b2b3 support bit does not follow strap");
   AST_RD_SUP_RSVD: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_BRIDGE_SUPPORT
      |=> cfg_rdata_o[5:0] == 6'h00)
      else $error("bridge support low bits not zero");
   AST_RD_DATA: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_POWER_DATA
      |=> cfg_rdata_o == `HSPM_POWER_DATA)
      else $error("power data byte not zero");
   AST_RD_ID_COMPAT: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_SWAP_ID && compat_mode_i
      |=> cfg_rdata_o == `HSPM_SWAP_ID_COMPAT)
      else $error("compatible mode id wrong");
   AST_RD_NEXT: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_SWAP_NEXT
      |=> cfg_rdata_o == `HSPM_NEXT_PTR)
      else $error("next pointer not zero");
   AST_RD_CTRL_RSVD: assert property (rd_req && cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL
      |=> cfg_rdata_o[5:4] == 2'h0 && !cfg_rdata_o[2] && !cfg_rdata_o[0])
      else $error("reserved control bits not zero");

   // -------------------------------------------------------------
   // assertions on writes, status and pins
   // -------------------------------------------------------------
   // a write alone must never move a status bit; only the pins may set them
   AST_LED_WR: assert property (wr_req && cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL
      |=> swap_r.led == $past(cfg_req_i.wdata[`HSPM_BIT_LED]))
      else $error("led bit not written");
   AST_MASK_WR: assert property (wr_req && cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL
      |=> swap_r.enum_mask == $past(cfg_req_i.wdata[`HSPM_BIT_ENUM_MASK]))
      else $error("mask bit not written");
   AST_PSTATE_WR: assert property (wr_req && cfg_req_i.addr == `HSPM_OFS_POWER_CTRL
      |=> pstate_r == $past(cfg_req_i.wdata[1:0]))
      else $error("power state not written");
   AST_WR_NO_INS: assert property (wr_req && cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL
      && !swap_r.inserted && !preload_done |=> !swap_r.inserted)
      else $error("write set inserted status");
   AST_WR_NO_EXT: assert property (wr_req && cfg_req_i.addr == `HSPM_OFS_SWAP_CTRL
      && !swap_r.extracted && handle_closed |=> !swap_r.extracted)
      else $error("write set extracted status");

   // status bits and enumeration output
   AST_EXT_CAUSE: assert property ($rose(swap_r.extracted)
      |-> !$past(handle_closed) && !$past(swap_r.inserted))
      else $error("extracted set without cause");
   AST_INS_AFTER_EXT: assert property ($rose(swap_r.inserted)
      |-> !$past(swap_r.extracted))
      else $error("inserted set while extracted");
   AST_EXT_MASKED: assert property (swap_r.enum_mask && !handle_closed && !swap_r.inserted
      |=> swap_r.extracted)
      else $error("mask blocked extracted status");
   AST_INS_MASKED: assert property (swap_r.enum_mask && !swap_r.inserted && !swap_r.extracted
      && preload_done && handle_closed |=> swap_r.inserted)
      else $error("mask blocked inserted status");
   AST_ENUM_CAUSE: assert property (swap_enumeration_out
      |-> (swap_r.inserted || swap_r.extracted) && !swap_r.enum_mask)
      else $error("enumeration output without cause");

   // led and secondary clocks
   AST_LED_REL: assert property ($fell(led_hold_r)
      |-> $past(handle_closed))
      else $error("led released with handle open");
   AST_CLK_RUN: assert property (!$past(strap) || pstate_r != hspm_pkg::HSPM_D3HOT
      |-> sec_clock_run_o)
      else $error("secondary clocks stopped");

   CV_INSERT:  cover property ($rose(swap_r.inserted));
   CV_EXTRACT: cover property ($rose(swap_r.extracted));
   CV_LED_REL: cover property ($fell(led_hold_r));
   CV_CLK_OFF: cover property ($fell(sec_clock_run_o));
   CV_MASKED:  cover property (swap_r.enum_mask && swap_r.inserted);

endmodule

// File: tb/hspm_board_model.sv
// board side model: ejector handle and serial rom preload
module hspm_board_model
#(
   parameter int LOAD_CYCLES = 6
)
(
   input  wire logic clock_i,
   input  wire logic handle_close_i,
   input  wire logic load_go_i,
   output logic      ejector_closed_o = 1'b0,
   output logic      rom_preload_done_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r = 0;
   // preload takes a while after it is started, like a real serial rom
   always_ff @(posedge clock_i)
   begin
      ejector_closed_o <= handle_close_i;
      cnt_r <= load_go_i ? ((cnt_r < LOAD_CYCLES) ? cnt_r + 1 : cnt_r) : 0;
      rom_preload_done_o <= load_go_i && (cnt_r == LOAD_CYCLES);
   end
endmodule

// File: tb/hspm_regs_test.sv
// self-checking bench of the swap and bridge power registers
module hspm_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {hspm_pkg::hspm_cfg_req_s req; logic [7:0] exp;} hspm_row_s;
   logic                    clock_i = 1'b0;
   logic                    rst_b_i = 1'b0;
   hspm_pkg::hspm_cfg_req_s req = '0;
   logic                    valid = 1'b0, compat = 1'b0, strap = 1'b1, close = 1'b1, load = 1'b0;
   logic                    ej, done, enum_o, led, clk_run;
   logic [7:0]              rdata;
   int                      n_errors = 0;
   int                      n_tests = 0;
   // optional write, then a read of the same offset
   hspm_row_s rows [12] = '{{1'b0, 8'hE2, 8'h00, 8'hC0}, {1'b0, 8'hE3, 8'h00, 8'h00},
      {1'b0, 8'hE4, 8'h00, 8'h06}, {1'b0, 8'hE5, 8'h00, 8'h00}, {1'b0, 8'hE6, 8'h00, 8'h00},
      {1'b0, 8'hE7, 8'h00, 8'h00}, {1'b1, 8'hE2, 8'hFF, 8'hC0}, {1'b1, 8'hE3, 8'hFF, 8'h00},
      {1'b1, 8'hE4, 8'h15, 8'h06}, {1'b1, 8'hE5, 8'hFF, 8'h00}, {1'b1, 8'hE6, 8'hFF, 8'h0A},
      {1'b1, 8'hE6, 8'h00, 8'h00}};

   hspm_regs hspm_regs_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_req_i(req), .cfg_req_valid_i(valid),
      .compat_mode_i(compat), .bus_power_strap_in(strap), .rom_preload_done_i(done), .ejector_closed_i(ej),
      .cfg_rdata_o(rdata), .swap_enumeration_out(enum_o), .swap_indicator_led_out(led), .sec_clock_run_o(clk_run));
   hspm_board_model hspm_board_model_i (.clock_i(clock_i), .handle_close_i(close), .load_go_i(load),
      .ejector_closed_o(ej), .rom_preload_done_o(done));

   initial forever #12.5 clock_i = ~clock_i;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req <= '{wr: wr, addr: a, wdata: d};
      valid <= 1'b1;
      @(posedge clock_i);
      valid <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("cfg_rdata_o", e, rdata);
   endtask

   // pins pass two sync flops, so the wait is bounded rather than exact
   task automatic wait_enum(input logic e);
      int i;
      for (i = 0; i < 20 && enum_o !== e; i++) tick(1);
      chk("swap_enumeration_out", e, enum_o);
      if (i == 20) wrap_up();
   endtask

   // -------------------------------------------------
   // stimulus
   // -------------------------------------------------
   initial
   begin
      tick(20);
      chk("led", 1, led);
      chk("enum", 0, enum_o);
      chk("clk_run", 1, clk_run);
      chk("rdata", 0, rdata);
      @(posedge clock_i) rst_b_i <= 1'b1;
      tick(6);
      foreach (rows[k])
      begin
         if (rows[k].req.wr) acc(1'b1, rows[k].req.addr, rows[k].req.wdata);
         rd(rows[k].req.addr, rows[k].exp);
      end
      $display("table done");
      acc(1'b1, 8'hE6, 8'h08);
      chk("led", 1, led);
      acc(1'b1, 8'hE6, 8'h00);
      chk("led", 0, led);
      @(posedge clock_i) compat <= 1'b1;
      rd(8'hE4, 8'h00);
      @(posedge clock_i) compat <= 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         acc(1'b1, 8'hE0, s[7:0]);
         chk("clk_run", s != 3, clk_run);
      end
      @(posedge clock_i) strap <= 1'b0;
      tick(4);
      rd(8'hE2, 8'h00);
      acc(1'b1, 8'hE0, 8'h03);
      chk("clk_run", 1, clk_run);
      acc(1'b1, 8'hE0, 8'h00);
      $display("power done");
      @(posedge clock_i) load <= 1'b1;
      wait_enum(1'b1);
      rd(8'hE6, 8'h80);
      acc(1'b1, 8'hE6, 8'h02);
      chk("enum", 0, enum_o);
      rd(8'hE6, 8'h82);
      acc(1'b1, 8'hE6, 8'h00);
      chk("enum", 1, enum_o);
      @(posedge clock_i) close <= 1'b0;
      tick(8);
      rd(8'hE6, 8'h80);
      $display("insertion done");
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      load <= 1'b0;
      tick(3);
      @(posedge clock_i) rst_b_i <= 1'b1;
      tick(6);
      acc(1'b1, 8'hE6, 8'h08);
      acc(1'b1, 8'hE6, 8'h00);
      chk("led", 1, led);
      @(posedge clock_i) close <= 1'b1;
      tick(8);
      chk("led", 0, led);
      @(posedge clock_i) close <= 1'b0;
      wait_enum(1'b1);
      rd(8'hE6, 8'h40);
      @(posedge clock_i) load <= 1'b1;
      @(posedge clock_i) close <= 1'b1;
      tick(14);
      rd(8'hE6, 8'h40);
      $display("extraction done");
      wrap_up();
   end
endmodule
